// ---- logic/rsmc_pin_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module rsmc_pin_ctrl (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic pin_rst_active,
  input wire logic [1:0] mode,
  input wire logic bus_cs_n_i,
  input wire logic bus_wr_n_i,
  input wire logic bus_rd_n_i,
  input wire logic bus_ale_i,
  input wire logic bus_en_i,
  input wire logic bus_data_oe_i,
  input wire logic port_oe_i,
  output logic chip_select_zero_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic ale_o,
  output logic strobe_oe_o,
  output logic addr_oe_o,
  output logic data_oe_o,
  output logic bclk_oe_o,
  output logic port_oe_o
);
  import rsmc_pkg::*;

  typedef struct packed {
    logic [3:0] lvl;
    logic [4:0] oe;
  } rsmc_pins_t;

  rsmc_pins_t q, n;

  always_comb begin
    n = q;
    if (pin_rst_active && mode == RSMC_MODE_MICRO) begin
      n.lvl = 4'hE;  // strobes high, ale low
      n.oe = 5'h1A;  // data in, ports in, address and clock out
    end else if (pin_rst_active) begin
      n.lvl = 4'hE;
      n.oe = 5'h00;  // all pins inputs
    end else begin
      n.lvl = {bus_cs_n_i, bus_wr_n_i, bus_rd_n_i, bus_ale_i};
      n.oe = {bus_en_i, bus_en_i, bus_data_oe_i, bus_en_i, port_oe_i};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '{lvl: 4'hE, oe: 5'h00};
    end else if (ce) begin
      q <= n;
    end
  end

  assign chip_select_zero_n_o = q.lvl[3];
  assign wr_n_o = q.lvl[2];
  assign rd_n_o = q.lvl[1];
  assign ale_o = q.lvl[0];
  assign strobe_oe_o = q.oe[4];
  assign addr_oe_o = q.oe[3];
  assign data_oe_o = q.oe[2];
  assign bclk_oe_o = q.oe[1];
  assign port_oe_o = q.oe[0];
endmodule
`default_nettype wire

// ---- logic/rsmc_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module rsmc_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import rsmc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rsmc_sync_t;

  rsmc_sync_t q, n;

  always_comb begin
    n = q;
    n.s1 = d_i;
    n.s2 = q.s1;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= {RST_VAL, RST_VAL};
    end else if (ce) begin
      q <= n;
    end
  end

  assign q_o = q.s2;
endmodule
`default_nettype wire

// ---- logic/rsmc_top.sv ----
// Notes on behaviour
// - writes to the processor mode register are ignored unless its write-enable bit is 1.
// - the mode field survives software, watchdog, oscillator-stop, monitor 1 and monitor 2 resets.
// - the bus option bits act only in memory expansion or microprocessor mode.
// - writing 1 to bit 3 of the processor mode register starts a software reset.
// - each reset but power-on and monitor 0 sets its own cause flag and clears the others, with the listed exceptions.
// - the cold/warm flag clears on power-on or a monitor 0 reset and is set only by software writing 1.
// - the oscillator-stop flag clears on power-on, a write of 0 or any reset but a pin or oscillator-stop reset, and is never set by software.
// - the option byte cannot be written by software and reads all ones once erased.
// - option byte selections apply in single-chip and memory expansion modes only.
// - code protection is active only when cancel bit is 1 and protect bit is 0.
// - the detector level bit is honoured in single-chip mode and ignored in boot mode.
// - the detector start bit is honoured only in single-chip mode.
// - while the reset pin is low in single-chip mode all port pins are inputs.
// - while reset is low in microprocessor mode strobes are high, ale low, data in, address and clock out.
// - the processor mode register resets to 00h or 03h after the mode-select strap.
`timescale 1ns/1ns
`default_nettype none
module rsmc_top #(
  parameter logic [5:0] HOLD_CYC = rsmc_pkg::RSMC_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic reset_pin_n,
  input wire logic mode_select_pin,
  input wire logic programming_mode_in,
  input wire logic vmon0_det,
  input wire logic vmon1_det,
  input wire logic vmon2_det,
  input wire logic osc_stop_det,
  input wire logic wdt_underflow,
  input wire logic [7:0] option_byte_in,
  input wire logic option_erased,
  output logic sys_rst_n_o,
  output logic [1:0] mode_o,
  output logic [4:0] bus_opt_o,
  output logic watchdog_autostart_o,
  output logic count_source_protect_o,
  output logic code_protect_o,
  output logic detector_level_o,
  output logic detector_start_o,
  input wire logic bus_cs_n_i,
  input wire logic bus_wr_n_i,
  input wire logic bus_rd_n_i,
  input wire logic bus_ale_i,
  input wire logic bus_en_i,
  input wire logic bus_data_oe_i,
  input wire logic port_oe_i,
  output logic chip_select_zero_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic ale_o,
  output logic strobe_oe_o,
  output logic addr_oe_o,
  output logic data_oe_o,
  output logic bclk_oe_o,
  output logic port_oe_o
);
  import rsmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    rsmc_state_t st;
    rsmc_cause_t cause;
    logic [5:0] cnt;
    logic [7:0] pm;
    logic [7:0] flags;
    logic [7:0] wp;
    logic [7:0] opt;
    logic [7:0] irq_st;
    logic [7:0] irq_msk;
    logic ack;
    logic [7:0] rdat;
    logic [4:0] bus_opt;
    logic [4:0] eff;
  } rsmc_top_t;

  rsmc_top_t q, n;

  logic [6:0] pins_s;
  logic pin_low;
  logic strap_hi;
  logic boot_s;
  logic vm0_s;
  logic vm1_s;
  logic vm2_s;
  logic osd_s;
  logic req;
  logic wr;
  logic sw_req;
  rsmc_cause_t new_cause;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  rsmc_sync #(
    .W(7),
    .RST_VAL(RSMC_SYNC_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .d_i({reset_pin_n, mode_select_pin, programming_mode_in,
          vmon0_det, vmon1_det, vmon2_det, osc_stop_det}),
    .q_o(pins_s)
  );

  assign pin_low = ~pins_s[6];
  assign strap_hi = pins_s[5];
  assign boot_s = pins_s[4];
  assign vm0_s = pins_s[3];
  assign vm1_s = pins_s[2];
  assign vm2_s = pins_s[1];
  assign osd_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // bus request decode

  // ack itself blocks a second take of a held request
  assign req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr = req & wb_we_i & wb_sel_i[0] & (q.st == RSMC_ST_RUN);
  assign sw_req = wr && wb_adr_i == RSMC_OFF_PM && q.wp[RSMC_WP_PM_EN]
                  && wb_dat_i[RSMC_PM_SWRST];

  // level sources restart the hold for as long as they stay active
  always_comb begin
    if (vm0_s) begin
      new_cause = RSMC_C_VM0;
    end else if (pin_low) begin
      new_cause = RSMC_C_PIN;
    end else if (vm1_s) begin
      new_cause = RSMC_C_VM1;
    end else if (vm2_s) begin
      new_cause = RSMC_C_VM2;
    end else if (osd_s) begin
      new_cause = RSMC_C_OSD;
    end else if (wdt_underflow) begin
      new_cause = RSMC_C_WDT;
    end else if (sw_req) begin
      new_cause = RSMC_C_SW;
    end else begin
      new_cause = RSMC_C_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = q;
    n.ack = req;

    if (req) begin
      unique case (wb_adr_i)
        RSMC_OFF_PM: n.rdat = q.pm & ~(8'h01 << RSMC_PM_SWRST);
        RSMC_OFF_CAUSE: n.rdat = q.flags;
        RSMC_OFF_WPROT: n.rdat = q.wp;
        RSMC_OFF_OPT: n.rdat = q.opt;
        RSMC_OFF_IRQ_ST: n.rdat = q.irq_st;
        RSMC_OFF_IRQ_MSK: n.rdat = q.irq_msk;
        default: n.rdat = 8'h00;
      endcase
    end

    if (wr) begin
      unique case (wb_adr_i)
        RSMC_OFF_PM: begin
          if (q.wp[RSMC_WP_PM_EN]) begin
            n.pm = wb_dat_i[7:0] & ~(8'h01 << RSMC_PM_SWRST);
          end
        end
        RSMC_OFF_CAUSE: begin
          if (wb_dat_i[RSMC_CF_CWR]) begin
            n.flags[RSMC_CF_CWR] = 1'b1;
          end
          if (!wb_dat_i[RSMC_CF_OSD]) begin
            n.flags[RSMC_CF_OSD] = 1'b0;
          end
        end
        RSMC_OFF_WPROT: n.wp = wb_dat_i[7:0] & RSMC_WPROT_MASK;
        RSMC_OFF_IRQ_ST: n.irq_st = q.irq_st & ~wb_dat_i[7:0];
        RSMC_OFF_IRQ_MSK: n.irq_msk = wb_dat_i[7:0];
        default: n.pm = n.pm;  // option byte and holes take no write
      endcase
    end

    // reset entry overrides a bus write of the same cycle to pm, flags or wp; irq_msk and other irq_st writes still land
    if (new_cause != RSMC_C_NONE) begin
      n.st = RSMC_ST_HOLD;
      n.cause = new_cause;
      n.cnt = HOLD_CYC;
      n.wp = RSMC_WPROT_RST;
      n.pm = q.pm & 8'h03;  // mode field kept
      n.flags = 8'h00;  // flags cleared, then rebuilt on reset entry
      n.flags[RSMC_CF_CWR] = (new_cause == RSMC_C_VM0) ? 1'b0 : q.flags[RSMC_CF_CWR];
      n.flags[RSMC_CF_OSD] = (new_cause == RSMC_C_PIN) ? q.flags[RSMC_CF_OSD] : 1'b0;
      // event bit of this cause only, kept flags raise none; set beats a clear
      unique case (new_cause)
        RSMC_C_PIN: begin
          n.flags[RSMC_CF_PIN] = 1'b1;
          n.irq_st[RSMC_CF_PIN] = 1'b1;
        end
        RSMC_C_VM1: begin
          n.flags[RSMC_CF_VM1] = 1'b1;
          n.irq_st[RSMC_CF_VM1] = 1'b1;
        end
        RSMC_C_VM2: begin
          n.flags[RSMC_CF_VM2] = 1'b1;
          n.irq_st[RSMC_CF_VM2] = 1'b1;
        end
        RSMC_C_OSD: begin
          n.flags[RSMC_CF_OSD] = 1'b1;
          n.irq_st[RSMC_CF_OSD] = 1'b1;
        end
        RSMC_C_WDT: begin
          n.flags[RSMC_CF_WDT] = 1'b1;
          n.irq_st[RSMC_CF_WDT] = 1'b1;
        end
        RSMC_C_SW: begin
          n.flags[RSMC_CF_SW] = 1'b1;
          n.irq_st[RSMC_CF_SW] = 1'b1;
        end
        default: begin
          n.flags[RSMC_CF_CWR] = 1'b0;  // power-on or monitor 0 clear all
          n.irq_st[RSMC_IRQ_VM0] = 1'b1;
        end
      endcase
    end else if (q.st == RSMC_ST_HOLD) begin
      if (q.cnt <= 6'h01) begin
        n.st = RSMC_ST_RUN;
        n.cnt = 6'h00;
        // option byte sampled as every hold ends, strap only after a power-on, monitor 0 or pin reset
        if (q.cause == RSMC_C_POR || q.cause == RSMC_C_VM0 || q.cause == RSMC_C_PIN) begin
          n.pm = strap_hi ? RSMC_PM_RST_HIGH : RSMC_PM_RST_LOW;  // strap
        end
        n.opt = option_erased ? RSMC_OPT_ERASED : option_byte_in;
      end else begin
        n.cnt = q.cnt - 6'h01;
      end
    end

    // bus options gated by mode
    if (n.pm[1:0] == RSMC_MODE_MEMEXP || n.pm[1:0] == RSMC_MODE_MICRO) begin
      n.bus_opt = {n.pm[7:4], n.pm[2]};
    end else begin
      n.bus_opt = 5'h00;
    end

    // option byte effects
    n.eff = 5'h00;
    if (n.pm[1:0] != RSMC_MODE_MICRO) begin
      n.eff[4] = ~n.opt[RSMC_OB_WDT_AUTO];
      n.eff[3] = ~n.opt[RSMC_OB_CSP];
      n.eff[2] = n.opt[RSMC_OB_CODE_CANCEL] & ~n.opt[RSMC_OB_CODE_PROT];
    end
    if (n.pm[1:0] == RSMC_MODE_SINGLE && !boot_s) begin
      n.eff[1] = n.opt[RSMC_OB_DET_LVL];
      n.eff[0] = ~n.opt[RSMC_OB_DET_START];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q.st <= RSMC_ST_HOLD;
      q.cause <= RSMC_C_POR;
      q.cnt <= HOLD_CYC;
      q.pm <= RSMC_PM_RST_LOW;
      q.flags <= RSMC_CAUSE_RST;  // power-on clears every flag
      q.wp <= RSMC_WPROT_RST;
      q.opt <= RSMC_OPT_ERASED;
      q.irq_st <= RSMC_IRQ_RST;
      q.irq_msk <= RSMC_IRQ_RST;
      q.ack <= 1'b0;
      q.rdat <= 8'h00;
      q.bus_opt <= 5'h00;
      q.eff <= 5'h00;
    end else if (ce) begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin states around reset

  rsmc_pin_ctrl u_pins (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .pin_rst_active(pin_low),
    .mode(q.pm[1:0]),
    .bus_cs_n_i(bus_cs_n_i),
    .bus_wr_n_i(bus_wr_n_i),
    .bus_rd_n_i(bus_rd_n_i),
    .bus_ale_i(bus_ale_i),
    .bus_en_i(bus_en_i),
    .bus_data_oe_i(bus_data_oe_i),
    .port_oe_i(port_oe_i),
    .chip_select_zero_n_o(chip_select_zero_n_o),
    .wr_n_o(wr_n_o),
    .rd_n_o(rd_n_o),
    .ale_o(ale_o),
    .strobe_oe_o(strobe_oe_o),
    .addr_oe_o(addr_oe_o),
    .data_oe_o(data_oe_o),
    .bclk_oe_o(bclk_oe_o),
    .port_oe_o(port_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_dat_o = {24'h000000, q.rdat};
  assign wb_ack_o = q.ack;
  assign irq_o = |(q.irq_st & q.irq_msk);
  // internal reset stays low for the whole hold
  assign sys_rst_n_o = (q.st == RSMC_ST_RUN);
  assign mode_o = q.pm[1:0];
  assign bus_opt_o = q.bus_opt;
  assign watchdog_autostart_o = q.eff[4];
  assign count_source_protect_o = q.eff[3];
  assign code_protect_o = q.eff[2];
  assign detector_level_o = q.eff[1];
  assign detector_start_o = q.eff[0];
endmodule
`default_nettype wire

// ---- shared/rsmc_pkg.sv ----
`default_nettype none
package rsmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the wishbone bus
  localparam logic [7:0] RSMC_OFF_PM = 8'h00;
  localparam logic [7:0] RSMC_OFF_CAUSE = 8'h04;
  localparam logic [7:0] RSMC_OFF_WPROT = 8'h08;
  localparam logic [7:0] RSMC_OFF_OPT = 8'h0C;
  localparam logic [7:0] RSMC_OFF_IRQ_ST = 8'h10;
  localparam logic [7:0] RSMC_OFF_IRQ_MSK = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset, and the write mask of the protect register
  localparam logic [7:0] RSMC_PM_RST_LOW = 8'h00;
  localparam logic [7:0] RSMC_PM_RST_HIGH = 8'h03;
  localparam logic [7:0] RSMC_CAUSE_RST = 8'h00;
  localparam logic [7:0] RSMC_WPROT_RST = 8'h00;
  localparam logic [7:0] RSMC_IRQ_RST = 8'h00;
  localparam logic [7:0] RSMC_OPT_ERASED = 8'hFF;
  localparam logic [7:0] RSMC_WPROT_MASK = 8'h4B;
  localparam logic [6:0] RSMC_SYNC_RST = 7'h40;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int RSMC_PM_SWRST = 3;
  localparam int RSMC_WP_PM_EN = 1;
  localparam int RSMC_CF_CWR = 0;
  localparam int RSMC_CF_PIN = 1;
  localparam int RSMC_CF_SW = 2;
  localparam int RSMC_CF_WDT = 3;
  localparam int RSMC_CF_VM1 = 4;
  localparam int RSMC_CF_VM2 = 5;
  localparam int RSMC_CF_OSD = 6;
  localparam int RSMC_IRQ_VM0 = 0;
  localparam int RSMC_OB_WDT_AUTO = 0;
  localparam int RSMC_OB_CODE_CANCEL = 2;
  localparam int RSMC_OB_CODE_PROT = 3;
  localparam int RSMC_OB_DET_LVL = 5;
  localparam int RSMC_OB_DET_START = 6;
  localparam int RSMC_OB_CSP = 7;

  ////////////////////////////////////////////////////////////////////////////
  // mode field codes and timing
  localparam logic [1:0] RSMC_MODE_SINGLE = 2'h0;
  localparam logic [1:0] RSMC_MODE_MEMEXP = 2'h1;
  localparam logic [1:0] RSMC_MODE_MICRO = 2'h3;
  localparam logic [5:0] RSMC_HOLD_CYC = 6'h20;

  typedef enum logic [3:0] {
    RSMC_C_NONE, RSMC_C_POR, RSMC_C_VM0, RSMC_C_PIN, RSMC_C_VM1,
    RSMC_C_VM2, RSMC_C_OSD, RSMC_C_WDT, RSMC_C_SW
  } rsmc_cause_t;

  typedef enum logic {RSMC_ST_RUN, RSMC_ST_HOLD} rsmc_state_t;

endpackage
`default_nettype wire

// ---- test/rsmc_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module rsmc_checker #(
  parameter logic [5:0] HOLD_CYC = rsmc_pkg::RSMC_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic reset_pin_n,
  input wire logic mode_select_pin,
  input wire logic sys_rst_n_o,
  input wire logic [1:0] mode_o,
  input wire logic [4:0] bus_opt_o,
  input wire logic watchdog_autostart_o,
  input wire logic count_source_protect_o,
  input wire logic code_protect_o,
  input wire logic detector_level_o,
  input wire logic detector_start_o,
  input wire logic chip_select_zero_n_o,
  input wire logic wr_n_o,
  input wire logic rd_n_o,
  input wire logic ale_o,
  input wire logic strobe_oe_o,
  input wire logic addr_oe_o,
  input wire logic data_oe_o,
  input wire logic bclk_oe_o,
  input wire logic port_oe_o
);
  import rsmc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic opt_any;
  assign opt_any = watchdog_autostart_o | count_source_protect_o | code_protect_o | detector_level_o | detector_start_o;
  ////////////////////////////////////////////////////////////////////////////
  a_ack_follows: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  a_ack_single: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_mode_write_gate: assert property (
    $changed(mode_o) && sys_rst_n_o && $past(sys_rst_n_o) |-> wb_ack_o && wb_we_i && wb_adr_i == RSMC_OFF_PM)
    else $error("mode field changed without a mode register write");
  a_bus_opt_mode: assert property (
    bus_opt_o != 5'h0 |-> mode_o == RSMC_MODE_MEMEXP || mode_o == RSMC_MODE_MICRO)
    else $error("bus options active outside expansion modes");
  a_opt_micro_off: assert property (opt_any |-> mode_o != RSMC_MODE_MICRO)
    else $error("option selection active in microprocessor mode");
  a_det_single: assert property (
    detector_level_o || detector_start_o |-> mode_o == RSMC_MODE_SINGLE)
    else $error("detector option active outside single-chip mode");
  a_pin_resets: assert property (!reset_pin_n [*5] |-> !sys_rst_n_o)
    else $error("reset pin low without internal reset");
  a_single_inputs: assert property (
    !reset_pin_n [*5] ##0 (mode_o == RSMC_MODE_SINGLE && !mode_select_pin)
    |-> !port_oe_o && !data_oe_o && !strobe_oe_o && !addr_oe_o && !bclk_oe_o)
    else $error("pin driven during reset in single-chip mode");
  a_micro_pins: assert property (
    !reset_pin_n [*5] ##0 (mode_o == RSMC_MODE_MICRO && mode_select_pin)
    |-> chip_select_zero_n_o && wr_n_o && rd_n_o && !ale_o && strobe_oe_o && addr_oe_o && bclk_oe_o && !data_oe_o)
    else $error("wrong bus pin state during reset in microprocessor mode");
  c_sw_reset: cover property (wb_ack_o && $fell(sys_rst_n_o));
  c_irq: cover property ($rose(irq_o));
  c_micro_pin: cover property (!reset_pin_n && mode_o == RSMC_MODE_MICRO && mode_select_pin);
endmodule
bind rsmc_top rsmc_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .reset_pin_n(reset_pin_n),
  .mode_select_pin(mode_select_pin), .sys_rst_n_o(sys_rst_n_o), .mode_o(mode_o), .bus_opt_o(bus_opt_o),
  .watchdog_autostart_o(watchdog_autostart_o), .count_source_protect_o(count_source_protect_o),
  .code_protect_o(code_protect_o), .detector_level_o(detector_level_o), .detector_start_o(detector_start_o),
  .chip_select_zero_n_o(chip_select_zero_n_o), .wr_n_o(wr_n_o), .rd_n_o(rd_n_o), .ale_o(ale_o),
  .strobe_oe_o(strobe_oe_o), .addr_oe_o(addr_oe_o), .data_oe_o(data_oe_o), .bclk_oe_o(bclk_oe_o),
  .port_oe_o(port_oe_o));
`default_nettype wire

// ---- test/rsmc_top_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module rsmc_top_bench;
  import rsmc_pkg::*;
  logic clk_sys, nrst, ce, cyc, stb, we, strap, pin_n, erased, ack, irq, srn, boot;
  logic [4:0] optv;
  logic [7:0] adr, obyte;
  logic [31:0] wdat, rdat, got;
  logic [4:0] ev;
  logic [6:0] bus_in;
  logic [1:0] mode;
  logic [4:0] bopt;
  int fail_count, n_tests, pm, cause, st, msk, ob, i, oexp;
  int seed = 32'hA91575EC;
  int bitpos[7] = '{3, 0, 4, 5, 6, 1, 2};

  rsmc_top #(.HOLD_CYC(6'h04)) DUT (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .reset_pin_n(pin_n),
    .mode_select_pin(strap), .programming_mode_in(boot), .vmon0_det(ev[1]), .vmon1_det(ev[2]),
    .vmon2_det(ev[3]), .osc_stop_det(ev[4]), .wdt_underflow(ev[0]), .option_byte_in(obyte),
    .option_erased(erased), .sys_rst_n_o(srn), .mode_o(mode), .bus_opt_o(bopt),
    .watchdog_autostart_o(optv[4]), .count_source_protect_o(optv[3]), .code_protect_o(optv[2]),
    .detector_level_o(optv[1]), .detector_start_o(optv[0]),
    .bus_cs_n_i(bus_in[0]), .bus_wr_n_i(bus_in[1]), .bus_rd_n_i(bus_in[2]), .bus_ale_i(bus_in[3]),
    .bus_en_i(bus_in[4]), .bus_data_oe_i(bus_in[5]), .port_oe_i(bus_in[6]), .chip_select_zero_n_o(),
    .wr_n_o(), .rd_n_o(), .ale_o(), .strobe_oe_o(), .addr_oe_o(), .data_oe_o(), .bclk_oe_o(), .port_oe_o());

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) bus_in <= 7'($random(seed));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input int e);
    n_tests++;
    if (g !== 32'(e)) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, 32'(e));
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 50);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 50) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic wait_run();
    int k;
    k = 0;
    while (srn !== 1'b1 && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 200) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic regs();
    wb(1'b0, RSMC_OFF_PM, 8'h00);
    chk(got, pm & 'hF7);
    wb(1'b0, RSMC_OFF_CAUSE, 8'h00);
    chk(got, cause);
    wb(1'b0, RSMC_OFF_IRQ_ST, 8'h00);
    chk(got, st);
    chk(32'(irq), (st & msk) != 0);
    chk(32'(mode), pm & 3);
  endtask

  // k: 0 wdt, 1 vmon0, 2 vmon1, 3 vmon2, 4 osc stop, 5 pin, 6 software
  task automatic model_rst(input int k);
    if (k == 1) cause = 0;
    else if (k == 5) cause = (cause & 'h41) | 'h02;
    else cause = (cause & 'h01) | (1 << bitpos[k]);
    st = st | (1 << bitpos[k]);
    pm = (k == 1 || k == 5) ? (strap ? 3 : 0) : (pm & 3);
  endtask

  task automatic rst_ev(input int k);
    @(posedge clk_sys);
    if (k == 5) pin_n <= 1'b0;
    else ev <= 5'(1 << k);
    repeat (8) @(posedge clk_sys);
    chk(32'(srn), 0);
    model_rst(k);
    wb(1'b0, RSMC_OFF_CAUSE, 8'h00);
    chk(got, cause);
    pin_n <= 1'b1;
    ev <= 5'h0;
    wait_run();
    regs();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ce = 1'b1;
    nrst = 1'b0;
    {cyc, stb, we, adr, wdat} = '0;
    {strap, erased, ev, obyte, boot} = '0;
    pin_n = 1'b1;
    for (i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      nrst <= 1'b0;
      ob = $random(seed) & 'h9F;  // detector options kept at 0
      obyte <= 8'(ob[7] ? ob : ob & 'hFE);  // no autostart off with protection
      erased <= (i == 0);
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      wait_run();
      {pm, cause, st, msk} = '0;
      ob = erased ? 'hFF : obyte;
      regs();
      wb(1'b1, RSMC_OFF_OPT, ~ob[7:0]);
      wb(1'b0, RSMC_OFF_OPT, 8'h00);
      chk(got, ob);
      oexp = 32'({!ob[0], !ob[7], ob[2] & !ob[3], ob[5], !ob[6]});
      chk(32'(optv), oexp);
    end
    wb(1'b1, RSMC_OFF_PM, 8'h01);
    regs();
    wb(1'b1, RSMC_OFF_WPROT, 8'h02);
    wb(1'b1, RSMC_OFF_PM, 8'hF0);
    chk(32'(bopt), 0);
    wb(1'b1, RSMC_OFF_PM, 8'hF1);
    pm = 'hF1;
    chk(32'(bopt), 'h1E);
    wb(1'b0, 8'h20, 8'h00);
    chk(got, 0);
    wb(1'b1, RSMC_OFF_CAUSE, 8'h41);
    cause = cause | 1;
    regs();
    wb(1'b1, RSMC_OFF_IRQ_MSK, 8'hFF);
    msk = 'hFF;
    wb(1'b1, RSMC_OFF_PM, 8'h09);
    chk(32'(srn), 0);
    wait_run();
    model_rst(6);
    regs();
    for (i = 0; i < 5; i++) if (i != 1) rst_ev(i);
    wb(1'b1, RSMC_OFF_CAUSE, 8'h00);
    cause = cause & 'h01;
    regs();
    wb(1'b1, RSMC_OFF_IRQ_MSK, 8'h00);
    wb(1'b1, RSMC_OFF_IRQ_ST, 8'hFF);
    {msk, st} = '0;
    rst_ev(0);
    wb(1'b1, RSMC_OFF_IRQ_MSK, 8'h08);
    msk = 'h08;
    regs();
    wb(1'b1, RSMC_OFF_IRQ_ST, 8'h08);
    st = 0;
    regs();
    rst_ev(4);
    for (i = 0; i < 4; i++) begin
      strap <= (i > 1);
      boot <= (i == 1);
      rst_ev(5);
      chk(32'(optv), (i > 1) ? 0 : (i == 1) ? oexp & 'h1C : oexp);
    end
    strap <= 1'b0;
    boot <= 1'b0;
    rst_ev(1);
    summarize();
  end
endmodule
`default_nettype wire
